// *** core/parallel_port_regs.sv ***
// Summary of operation
// - Data register resets, latches on write rise
// - SPP data read returns live pins
// - Status held stable during host read
// - Bit 0 flags EPP 10 us timeout
// - Writing one clears timeout; zero ignored
// - Status bits 1 and 2 read zero
// - Bits 3-6 show live printer inputs
// - Bit 7 is complement of busy
// - Control bits 0-5 reset; 6-7 zero
// - Bits 0,1,3 driven inverted to pins
// - Bit 2 drives reinit pin uninverted
// - Enabled ack rising edge raises interrupt
// - Direction bit only with extended mode bit clear
// - Address write starts EPP address cycle
// - Address read latches pins at strobe end
// - Offsets 3-7 decoded only in EPP mode
// - Status writable only in EPP mode
// - Watchdog aborts long EPP cycle
// - Data windows run EPP data cycles
`timescale 1ns/1ps
`default_nettype none

module parallel_port_regs
  import parport_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      rstn,
  input  wire parport_pkg::hostIn_t      hostIn,
  output var  parport_pkg::hostOut_t     hostOut,
  input  wire parport_pkg::modeCfg_t     modeCfg,
  input  wire parport_pkg::printerIn_t   printerIn,
  output var  parport_pkg::printerOut_t  printerOut,
  input  wire logic [DATA_W-1:0]         parallelDataPinsIn,
  output var  logic [DATA_W-1:0]         parallelDataPinsOut,
  output var  logic                      parallelDataPinsOe
);

  import parport_pkg::*;

  logic [1:0]  rstSync;
  logic        rstnSafe;
  portState_t  s;
  portState_t  next_s;

  hostIn_t           h;
  printerIn_t        p;
  logic [DATA_W-1:0] pins;
  logic              eppOn;
  logic              extMode;
  logic              writeRise;
  logic              writeFall;
  logic              readFall;
  logic              readActive;
  logic              decoded;
  logic              eppWindow;
  logic              inCycle;
  logic              effWrite;
  logic [DATA_W-1:0] statusLive;
  logic [DATA_W-1:0] latched;

  // Reset release is synchronised so every state flop leaves reset together
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rstSync <= 2'b00;
    end
    else
    begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end

  assign rstnSafe = rstSync[1];

  always_comb
  begin
    next_s = s;

    // Pin inputs pass two flops before use
    next_s.hostSync[1] = s.hostSync[0];
    next_s.hostSync[0] = hostIn;
    next_s.prnSync[1]  = s.prnSync[0];
    next_s.prnSync[0]  = printerIn;
    next_s.pinSync[1]  = s.pinSync[0];
    next_s.pinSync[0]  = parallelDataPinsIn;
    next_s.cfgSync[1]  = s.cfgSync[0];
    next_s.cfgSync[0]  = modeCfg;

    h       = s.hostSync[1];
    p       = s.prnSync[1];
    pins    = s.pinSync[1];
    eppOn   = s.cfgSync[1].eppModeSel;
    extMode = s.cfgSync[1].extendedModeCfgBit;

    next_s.prevWriteN = h.hostWritePulseN;
    next_s.prevReadN  = h.hostReadPulseN;
    writeRise  = h.hostWritePulseN & ~s.prevWriteN;
    writeFall  = ~h.hostWritePulseN & s.prevWriteN;
    readFall   = ~h.hostReadPulseN & s.prevReadN;
    readActive = ~h.hostReadPulseN;

    eppWindow = h.addr >= OFS_EPP_ADDR;
    decoded   = ~eppWindow | eppOn;

    statusLive             = ZERO_BYTE;
    statusLive[ST_TIMEOUT] = s.eppTimeoutFlag;
    statusLive[ST_ERROR]   = p.printerErrorIn;
    statusLive[ST_SELECT]  = p.printerSelectedIn;
    statusLive[ST_PAPER]   = p.paperEndIn;
    statusLive[ST_ACK]     = p.printerAckIn;
    statusLive[ST_BUSY]    = ~p.printerBusyIn;

    // Register writes take effect at the trailing edge of the strobe
    if (writeRise && decoded)
    begin
      unique case (h.addr)
        OFS_DATA:
        begin
          next_s.dataReg = h.data;
        end
        OFS_STATUS:
        begin
          if (eppOn && h.data[ST_TIMEOUT])
          begin
            next_s.eppTimeoutFlag = 1'b0;
          end
        end
        OFS_CONTROL:
        begin
          next_s.ctl = h.data[CTL_W-1:0];
        end
        OFS_EPP_ADDR:
        begin
          next_s.eppAddr = h.data;
        end
        default:
        begin
          next_s.eppData = h.data;
        end
      endcase
    end

    // Status is frozen at the read's leading edge for its whole length
    if (readFall)
    begin
      next_s.statusSnap = statusLive;
    end

    // EPP cycle engine shared by the address and data windows
    unique case (s.eppState)
      EPP_IDLE:
      begin
        if (eppOn && eppWindow && (writeFall || readFall))
        begin
          next_s.eppIsWrite    = writeFall;
          next_s.eppIsAddr     = h.addr == OFS_EPP_ADDR;
          next_s.watchdog      = '0;
          next_s.hostOut.ready = 1'b0;
          next_s.eppState      = EPP_SETUP;
        end
      end
      EPP_SETUP:
      begin
        next_s.watchdog = s.watchdog + 1'b1;
        if (!p.printerBusyIn)
        begin
          next_s.eppState = EPP_STROBE;
        end
      end
      EPP_STROBE:
      begin
        next_s.watchdog = s.watchdog + 1'b1;
        if (p.printerBusyIn)
        begin
          if (!s.eppIsWrite)
          begin
            next_s.readHold = pins;
          end
          next_s.hostOut.ready = 1'b1;
          next_s.eppState      = EPP_DONE;
        end
      end
      EPP_DONE:
      begin
        if (h.hostWritePulseN && h.hostReadPulseN)
        begin
          next_s.eppState = EPP_IDLE;
        end
      end
    endcase

    // Watchdog abort; a timeout beats a same-cycle clear
    if ((s.eppState == EPP_SETUP || s.eppState == EPP_STROBE)
        && s.watchdog >= WDOG_CYCLES)
    begin
      next_s.eppTimeoutFlag = 1'b1;
      next_s.hostOut.ready  = 1'b1;
      next_s.eppState       = EPP_DONE;
    end

    // Host read data
    next_s.hostOut.dataOe = readActive && decoded;
    next_s.hostOut.data   = ZERO_BYTE;
    if (readActive && decoded)
    begin
      unique case (h.addr)
        OFS_DATA:
        begin
          next_s.hostOut.data = pins;
        end
        OFS_STATUS:
        begin
          // First cycle shows the value being frozen into the snapshot
          if (readFall)
          begin
            next_s.hostOut.data = statusLive;
          end
          else
          begin
            next_s.hostOut.data = s.statusSnap;
          end
        end
        OFS_CONTROL:
        begin
          next_s.hostOut.data = {2'b00, s.ctl};
        end
        default:
        begin
          // Latched byte is shown at the edge that raises ready
          next_s.hostOut.data = next_s.readHold;
        end
      endcase
    end

    // Parallel pin roles
    inCycle  = next_s.eppState == EPP_SETUP
               || next_s.eppState == EPP_STROBE;
    // An active strobe bit forces a write, so a stray read cannot fight
    effWrite = next_s.eppIsWrite | next_s.ctl[CT_STROBE];
    if (eppOn && inCycle)
    begin
      next_s.prnOut.strobeN           = ~effWrite;
      next_s.prnOut.lineFeedCtlN      =
        ~(next_s.eppState == EPP_STROBE && !next_s.eppIsAddr);
      next_s.prnOut.printerChooseCtlN =
        ~(next_s.eppState == EPP_STROBE && next_s.eppIsAddr);
      next_s.pinOe                    = effWrite;
    end
    else
    begin
      next_s.prnOut.strobeN           = ~next_s.ctl[CT_STROBE];
      next_s.prnOut.lineFeedCtlN      = ~next_s.ctl[CT_FEED];
      next_s.prnOut.printerChooseCtlN = ~next_s.ctl[CT_CHOOSE];
      next_s.pinOe = ~(~extMode & next_s.ctl[CT_DIR]);
    end
    next_s.prnOut.printerReinitCtl = next_s.ctl[CT_REINIT];
    // Level follows ack, so its rising edge is the request edge
    next_s.prnOut.irq = next_s.ctl[CT_IRQ_EN] & p.printerAckIn;

    // Write data passes straight through until the trailing edge latches it
    latched = next_s.eppIsAddr ? next_s.eppAddr : next_s.eppData;
    if (next_s.eppState != EPP_IDLE && next_s.eppIsWrite)
    begin
      next_s.pinOut = h.hostWritePulseN ? latched : h.data;
    end
    else
    begin
      next_s.pinOut = next_s.dataReg;
    end
  end

  always_ff @(posedge clk or negedge rstnSafe)
  begin
    if (!rstnSafe)
    begin
      s                                 <= '0;
      s.hostSync[0].hostWritePulseN     <= 1'b1;
      s.hostSync[0].hostReadPulseN      <= 1'b1;
      s.hostSync[1].hostWritePulseN     <= 1'b1;
      s.hostSync[1].hostReadPulseN      <= 1'b1;
      s.prevWriteN                      <= 1'b1;
      s.prevReadN                       <= 1'b1;
      s.dataReg                         <= DATA_RESET;
      s.ctl                             <= CTL_RESET;
      s.eppAddr                         <= DATA_RESET;
      s.eppData                         <= DATA_RESET;
      s.eppState                        <= EPP_IDLE;
      s.hostOut.ready                   <= 1'b1;
      s.prnOut.strobeN                  <= 1'b1;
      s.prnOut.lineFeedCtlN             <= 1'b1;
      s.prnOut.printerChooseCtlN        <= 1'b1;
      s.pinOe                           <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign hostOut             = s.hostOut;
  assign printerOut          = s.prnOut;
  assign parallelDataPinsOut = s.pinOut;
  assign parallelDataPinsOe  = s.pinOe;

endmodule // parallel_port_regs

`default_nettype wire

// *** core/parport_pkg.sv ***
`default_nettype none

package parport_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 3;
  localparam int WDOG_W = 12;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_DATA      = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_CONTROL   = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_EPP_ADDR  = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_EPP_DATA0 = 3'h4;
  localparam logic [ADDR_W-1:0] OFS_EPP_DATA3 = 3'h7;

  // Status bit positions
  localparam int ST_TIMEOUT = 0;
  localparam int ST_ERROR   = 3;
  localparam int ST_SELECT  = 4;
  localparam int ST_PAPER   = 5;
  localparam int ST_ACK     = 6;
  localparam int ST_BUSY    = 7;

  // Control bit positions
  localparam int CTL_W       = 6;
  localparam int CT_STROBE   = 0;
  localparam int CT_FEED     = 1;
  localparam int CT_REINIT   = 2;
  localparam int CT_CHOOSE   = 3;
  localparam int CT_IRQ_EN   = 4;
  localparam int CT_DIR      = 5;

  // Reset values
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam logic [CTL_W-1:0]  CTL_RESET  = 6'h00;
  localparam logic [DATA_W-1:0] ZERO_BYTE  = 8'h00;

  // Watchdog: EPP cycle limit
  localparam int CLK_PERIOD_PS = 5000;
  localparam int WDOG_LIMIT_PS = 10_000_000;
  localparam logic [WDOG_W-1:0] WDOG_CYCLES =
    WDOG_W'((WDOG_LIMIT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  typedef enum logic [1:0] {
    EPP_IDLE,
    EPP_SETUP,
    EPP_STROBE,
    EPP_DONE
  } eppState_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic              hostWritePulseN;
    logic              hostReadPulseN;
  } hostIn_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic              dataOe;
    logic              ready;
  } hostOut_t;

  typedef struct packed {
    logic printerErrorIn;
    logic printerSelectedIn;
    logic paperEndIn;
    logic printerAckIn;
    logic printerBusyIn;
  } printerIn_t;

  typedef struct packed {
    logic strobeN;
    logic lineFeedCtlN;
    logic printerReinitCtl;
    logic printerChooseCtlN;
    logic irq;
  } printerOut_t;

  typedef struct packed {
    logic eppModeSel;
    logic extendedModeCfgBit;
  } modeCfg_t;

  typedef struct packed {
    hostIn_t    [1:0]             hostSync;
    printerIn_t [1:0]             prnSync;
    logic       [1:0][DATA_W-1:0] pinSync;
    modeCfg_t   [1:0]             cfgSync;
    logic                         prevWriteN;
    logic                         prevReadN;
    logic [DATA_W-1:0]            dataReg;
    logic [CTL_W-1:0]             ctl;
    logic                         eppTimeoutFlag;
    logic [DATA_W-1:0]            eppAddr;
    logic [DATA_W-1:0]            eppData;
    logic [DATA_W-1:0]            readHold;
    logic [DATA_W-1:0]            statusSnap;
    eppState_t                    eppState;
    logic                         eppIsWrite;
    logic                         eppIsAddr;
    logic [WDOG_W-1:0]            watchdog;
    hostOut_t                     hostOut;
    printerOut_t                  prnOut;
    logic [DATA_W-1:0]            pinOut;
    logic                         pinOe;
  } portState_t;

endpackage

`default_nettype wire

// *** verif/parallel_port_regs_properties.sv ***
`timescale 1ns/1ps
`default_nettype none

module parallel_port_regs_properties
  import parport_pkg::*;
(
  input wire logic                     clk,
  input wire logic                     rstn,
  input wire parport_pkg::hostIn_t     hostIn,
  input wire parport_pkg::hostOut_t    hostOut,
  input wire parport_pkg::modeCfg_t    modeCfg,
  input wire parport_pkg::printerIn_t  printerIn,
  input wire parport_pkg::printerOut_t printerOut,
  input wire logic [DATA_W-1:0]        parallelDataPinsIn,
  input wire logic [DATA_W-1:0]        parallelDataPinsOut,
  input wire logic                     parallelDataPinsOe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // Long status read: covers the sync and snapshot latency
  logic [2:0] stCnt;
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      stCnt <= 3'h0;
    else if (hostIn.hostReadPulseN || hostIn.addr != OFS_STATUS)
      stCnt <= 3'h0;
    else if (stCnt != 3'h7)
      stCnt <= stCnt + 3'h1;

  // Cycles that ready has been low; the watchdog must end any EPP cycle
  logic [11:0] rdyLowCnt;
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      rdyLowCnt <= 12'h000;
    else if (hostOut.ready)
      rdyLowCnt <= 12'h000;
    else if (rdyLowCnt != 12'hfff)
      rdyLowCnt <= rdyLowCnt + 12'h001;

  a_status_zero_bits: assert property (stCnt == 3'h7 && hostOut.dataOe
    |-> hostOut.data[2:1] == 2'b00) else $error("status bits 1-2 not zero");
  a_status_frozen: assert property (stCnt == 3'h7 && $past(stCnt) == 3'h7
    && hostOut.dataOe && $past(hostOut.dataOe) |-> $stable(hostOut.data))
    else $error("status changed during read");
  a_ready_bounded: assert property (rdyLowCnt <= 12'h7da)
    else $error("EPP cycle not aborted");
  a_epp_only: assert property ($fell(hostOut.ready)
    |-> $past(modeCfg.eppModeSel, 3)) else $error("EPP cycle outside EPP");
  a_addr_after_wait: assert property ($fell(printerOut.printerChooseCtlN)
    && !hostOut.ready |-> !$past(printerIn.printerBusyIn, 3))
    else $error("address strobe before wait low");
  a_write_drives: assert property (!hostOut.ready && !printerOut.strobeN
    |-> parallelDataPinsOe) else $error("EPP write not driving pins");
  a_read_floats: assert property (!hostOut.ready && printerOut.strobeN
    && !printerOut.printerChooseCtlN |-> !parallelDataPinsOe)
    else $error("EPP read driving pins");
  a_irq_cause: assert property (printerOut.irq
    |-> $past(printerIn.printerAckIn, 2) || $past(printerIn.printerAckIn, 3)
    || $past(printerIn.printerAckIn, 4)) else $error("irq without ack");
  a_printer_mode_out: assert property ($past(modeCfg.extendedModeCfgBit, 3)
    && $past(modeCfg.extendedModeCfgBit, 4)
    && $past(modeCfg.extendedModeCfgBit, 5) && !$past(modeCfg.eppModeSel, 3)
    |-> parallelDataPinsOe) else $error("printer mode pins not driven");

  c_irq: cover property ($rose(printerOut.irq));
  c_epp_cycle: cover property ($fell(hostOut.ready));
  c_status_read: cover property (stCnt == 3'h7 && hostOut.dataOe);
endmodule // parallel_port_regs_properties

bind parallel_port_regs parallel_port_regs_properties u_props (
  .clk(clk), .rstn(rstn), .hostIn(hostIn), .hostOut(hostOut),
  .modeCfg(modeCfg), .printerIn(printerIn), .printerOut(printerOut),
  .parallelDataPinsIn(parallelDataPinsIn),
  .parallelDataPinsOut(parallelDataPinsOut),
  .parallelDataPinsOe(parallelDataPinsOe));

`default_nettype wire

// *** verif/epp_peripheral_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module epp_peripheral_model
  import parport_pkg::*;
(
  input  wire logic                     clk,
  input  wire parport_pkg::printerOut_t prnOut,
  input  wire logic [7:0]               pinsOut,
  input  wire logic                     pinsOe,
  input  wire parport_pkg::printerIn_t  levels,
  input  wire logic                     eppOn,
  input  wire logic                     hang,
  input  wire logic                     drvEn,
  input  wire logic [7:0]               drvByte,
  output var  parport_pkg::printerIn_t  prnIn,
  output var  logic [7:0]               pinsIn,
  output var  logic [7:0]               gotByte
);
  logic       strobing;
  logic       waitLvl  = 1'b0;
  logic [7:0] lastPins = 8'h00;
  int         holdCnt  = 0;

  assign strobing = !prnOut.lineFeedCtlN || !prnOut.printerChooseCtlN;

  // Wait goes high a few cycles into a strobe; hang models a dead peer
  always @(negedge clk)
    if (!strobing)
    begin
      waitLvl <= 1'b0;
      holdCnt <= 0;
    end
    else if (!hang && holdCnt == 3)
      waitLvl <= 1'b1;
    else
      holdCnt <= holdCnt + 1;

  always_comb
  begin
    prnIn = levels;
    if (eppOn)
      prnIn.printerBusyIn = waitLvl;
  end

  // Released bus toggles so a stale value never reads as valid
  always_comb
    if (pinsOe)
      pinsIn = pinsOut;
    else if (drvEn || strobing)
      pinsIn = drvByte;
    else
      pinsIn = ~lastPins;

  always @(posedge clk)
    lastPins <= pinsIn;

  always @(negedge strobing)
    gotByte <= pinsIn;
endmodule // epp_peripheral_model

`default_nettype wire

// *** verif/parallel_port_regs_bench.sv ***
`timescale 1ns/1ps
`default_nettype none

module parallel_port_regs_bench;
  import parport_pkg::*;
  typedef struct packed {
    logic [2:0] a;
    logic [7:0] w;
    printerIn_t p;
    logic [7:0] e;
  } row_t;

  logic        clk   = 1'b0;
  logic        rstn  = 1'b0;
  logic        eppOn = 1'b0;
  logic        hang  = 1'b0;
  logic        drvEn = 1'b0;
  logic [7:0]  drvByte = 8'h00;
  logic [7:0]  gotByte, pinsIn, pinsOut, rd;
  logic        pinsOe;
  logic        oeSeen;
  hostIn_t     hi = '{3'h0, 8'h00, 1'b1, 1'b1};
  hostOut_t    ho;
  modeCfg_t    mc = '{1'b0, 1'b0};
  printerIn_t  lv = '0;
  printerIn_t  prnIn;
  printerOut_t po;
  int          bad_count = 0;
  int          total_checks = 0;
  int          cyc = 0;
  row_t rows [6] = '{'{3'h0, 8'hA5, 5'h00, 8'hA5}, '{3'h0, 8'h5A, 5'h00, 8'h5A},
    '{3'h1, 8'h00, 5'h15, 8'h28}, '{3'h1, 8'h00, 5'h0A, 8'hD0},
    '{3'h2, 8'hFF, 5'h00, 8'h3F}, '{3'h2, 8'hC4, 5'h00, 8'h04}};

  always #2.5 clk = ~clk;

  parallel_port_regs u_dut (.clk(clk), .rstn(rstn), .hostIn(hi),
    .hostOut(ho), .modeCfg(mc), .printerIn(prnIn), .printerOut(po),
    .parallelDataPinsIn(pinsIn), .parallelDataPinsOut(pinsOut),
    .parallelDataPinsOe(pinsOe));
  epp_peripheral_model u_peer (.clk(clk), .prnOut(po), .pinsOut(pinsOut),
    .pinsOe(pinsOe), .levels(lv), .eppOn(eppOn), .hang(hang),
    .drvEn(drvEn), .drvByte(drvByte), .prnIn(prnIn), .pinsIn(pinsIn),
    .gotByte(gotByte));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(string n, logic [7:0] e, logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  // Strobe is held until ready, so EPP cycles stretch the host access
  task automatic waitReady();
    int k;
    k = 0;
    repeat (6) @(negedge clk);
    while (ho.ready !== 1'b1 && k < 2500)
    begin
      @(negedge clk);
      k++;
    end
    check("ready", 8'h01, {7'h00, ho.ready});
  endtask

  task automatic wr(logic [2:0] a, logic [7:0] d);
    hi.addr = a;
    hi.data = d;
    hi.hostWritePulseN = 1'b0;
    waitReady();
    hi.hostWritePulseN = 1'b1;
    repeat (8) @(negedge clk);
  endtask

  task automatic rd8(logic [2:0] a, output logic [7:0] d);
    hi.addr = a;
    hi.hostReadPulseN = 1'b0;
    waitReady();
    repeat (4) @(negedge clk);
    d = ho.data;
    oeSeen = ho.dataOe;
    hi.hostReadPulseN = 1'b1;
    repeat (8) @(negedge clk);
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      bad_count++;
      print_verdict();
    end
  end

  initial
  begin
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    repeat (8) @(negedge clk);
    for (int i = 0; i < 6; i++)
    begin
      lv = rows[i].p;
      if (rows[i].a != OFS_STATUS)
        wr(rows[i].a, rows[i].w);
      rd8(rows[i].a, rd);
      check("row read", rows[i].e, rd);
      if (rows[i].a == OFS_CONTROL)
        check("ctl pins", {4'h0, ~rows[i].w[3], rows[i].w[2], ~rows[i].w[1],
          ~rows[i].w[0]}, {4'h0, po.printerChooseCtlN, po.printerReinitCtl,
          po.lineFeedCtlN, po.strobeN});
      if (rows[i].a == OFS_DATA)
        check("data pins", rows[i].w, pinsOut);
    end
    // Status inputs move mid-read; the host must still see the first value
    lv = 5'h0A;
    repeat (4) @(negedge clk);
    hi.addr = OFS_STATUS;
    hi.hostReadPulseN = 1'b0;
    repeat (8) @(negedge clk);
    lv = '0;
    repeat (8) @(negedge clk);
    check("status held", 8'hD0, ho.data);
    hi.hostReadPulseN = 1'b1;
    repeat (8) @(negedge clk);
    wr(OFS_CONTROL, 8'h14);
    lv.printerAckIn = 1'b1;
    repeat (6) @(negedge clk);
    check("irq on", 8'h01, {7'h00, po.irq});
    wr(OFS_CONTROL, 8'h04);
    check("irq off", 8'h00, {7'h00, po.irq});
    lv = '0;
    wr(OFS_CONTROL, 8'h24);
    drvEn = 1'b1;
    drvByte = 8'h3C;
    rd8(OFS_DATA, rd);
    check("live pins", 8'h3C, rd);
    check("read oe", 8'h01, {7'h00, oeSeen});
    mc.extendedModeCfgBit = 1'b1;
    repeat (6) @(negedge clk);
    check("printer mode oe", 8'h01, {7'h00, pinsOe});
    mc.extendedModeCfgBit = 1'b0;
    drvEn = 1'b0;
    wr(OFS_CONTROL, 8'h04);
    wr(OFS_EPP_ADDR, 8'h77);
    rd8(OFS_EPP_ADDR, rd);
    check("undecoded", 8'h00, rd);
    check("undecoded oe", 8'h00, {7'h00, oeSeen});
    mc.eppModeSel = 1'b1;
    eppOn = 1'b1;
    repeat (6) @(negedge clk);
    wr(OFS_EPP_ADDR, 8'h96);
    check("addr out", 8'h96, gotByte);
    wr(3'h5, 8'h69);
    check("data out", 8'h69, gotByte);
    drvByte = 8'hC3;
    rd8(OFS_EPP_ADDR, rd);
    check("addr in", 8'hC3, rd);
    drvByte = 8'h5E;
    rd8(OFS_EPP_DATA3, rd);
    check("data in", 8'h5E, rd);
    hang = 1'b1;
    wr(OFS_EPP_DATA0, 8'h11);
    hang = 1'b0;
    rd8(OFS_STATUS, rd);
    check("epp_timeout_flag set", 8'h01, rd & 8'h01);
    wr(OFS_STATUS, 8'h00);
    rd8(OFS_STATUS, rd);
    check("zero keeps", 8'h01, rd & 8'h01);
    wr(OFS_STATUS, 8'h01);
    rd8(OFS_STATUS, rd);
    check("one clears", 8'h00, rd & 8'h01);
    hang = 1'b1;
    wr(OFS_EPP_DATA0, 8'h22);
    hang = 1'b0;
    rstn = 1'b0;
    repeat (5) @(negedge clk);
    check("reset pins", 8'h00, pinsOut);
    check("reset ctl", 8'h0B, {4'h0, po.printerChooseCtlN,
      po.printerReinitCtl, po.lineFeedCtlN, po.strobeN});
    rstn = 1'b1;
    repeat (8) @(negedge clk);
    rd8(OFS_STATUS, rd);
    check("reset epp_timeout_flag", 8'h00, rd & 8'h01);
    rd8(OFS_CONTROL, rd);
    check("reset control", 8'h00, rd);
    print_verdict();
  end
endmodule // parallel_port_regs_bench

`default_nettype wire
